// ==== rtl/user_reg_upper.v ====
// Summary of operation
// - custom command region 0x400 to 0xFFF decoded apart from other regions
// - full-word writes at 0x400..0x47C load submit dwords, channel 0 then channel 1
// - reads at 0x500..0x51C return completion dwords 0..3 per channel
// - read of 0x800 returns the controller core version unmodified
// - region 0x1000 to 0x1FFF holds tester status and is read only
// - first mismatch byte address is 57 bits, low and high words
// - tested byte count is 57 bits at 0x1008 and 0x100C
// - expected 512-bit word at first mismatch, sixteen words, low first
// - received 512-bit word at first mismatch, sixteen words, low first
// - channel 0 identify windows for controller and namespace data
// - channel 1 identify windows for controller and namespace data
// - 8 KB read write custom memory window per channel
// - read data returned four cycles after request, strobe via flops
// - user status bit 0 busy, bit 1 error
// - link status speed in bits 16 and 3:2, width in bits 6:4
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`include "user_reg_defines.vh"
module user_reg_upper #(
    parameter ADDR_W = 18,
    parameter MEM_ADDR_W = 11
) (
    // clock and reset
    input wire clock,
    input wire resetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // controller status
    input wire controller_busy,
    input wire controller_error,
    input wire [31:0] version_number,
    input wire [16:0] link_status_ch0,
    input wire [16:0] link_status_ch1,
    // custom command entries
    output reg [511:0] submit_dwords_ch0,
    output reg [511:0] submit_dwords_ch1,
    input wire [127:0] complete_dwords_ch0,
    input wire [127:0] complete_dwords_ch1,
    // pattern tester
    input wire test_start,
    input wire mismatch,
    input wire [56:0] mismatch_address,
    input wire [56:0] tested_bytes,
    input wire [511:0] expected_data,
    input wire [511:0] received_data,
    // identify memories, one shared read port
    output reg [MEM_ADDR_W-1:0] ident_addr,
    output reg [1:0] ident_select,
    input wire [31:0] ident_rdata,
    // custom memory port
    output reg [MEM_ADDR_W-1:0] custom_memory_addr,
    output reg custom_memory_sel,
    output reg custom_memory_wr,
    output reg [31:0] custom_memory_wdata,
    input wire [31:0] custom_memory_rdata
);

// one-hot read handshake states
localparam ST_IDLE = 3'b001;
localparam ST_WAIT = 3'b010;
localparam ST_DONE = 3'b100;

// where the read word comes from: a register, or one of the memories
localparam SRC_DIRECT = 2'd0;
localparam SRC_IDENT = 2'd1;
localparam SRC_CUSTOM = 2'd2;

reg [2:0] state_r;
reg [2:0] state_nxt;
reg read_request;
wire read_valid;
reg [31:0] read_stage1_r;
reg [31:0] read_stage2_r;
reg [1:0] source_r;
reg mismatch_seen_r;
reg [56:0] fail_address_r;
reg [511:0] expected_r;
reg [511:0] received_r;
reg [31:0] version_r;
reg [16:0] link0_r;
reg [16:0] link1_r;
reg busy_r;
reg error_r;
reg [31:0] direct_data;
reg [1:0] direct_source;

// pick one 32-bit word of a 512-bit value
function [31:0] word16;
    input [511:0] vec;
    input [3:0] index;
    begin
        word16 = vec[index*32 +: 32];
    end
endfunction

// true when addr lies inside lo..hi
function in_range;
    input [17:0] addr;
    input [17:0] lo;
    input [17:0] hi;
    begin
        in_range = (addr >= lo) && (addr <= hi);
    end
endfunction

// true for the read write custom memory window of either channel
function in_custom_window;
    input [17:0] a;
    begin
        in_custom_window = (a >= `CUSTOM_MEM_CH0) && (a <= `CUSTOM_MEM_LAST);
    end
endfunction

wire [17:0] addr = paddr[17:0];
wire setup = psel && !penable;
// access phase of a write, the only cycle in which a submit dword may change
wire write_access = psel && penable && pwrite;
// partial strobes drop a submit dword write rather than merge a half-old dword; custom memory writes ignore pstrb
wire full_word = (pstrb == 4'hF);

// register the core status inputs; the controller shares this clock, so
// one register only shortens the path and no synchroniser is needed; a
// value read back is therefore one cycle older than the live input
always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        version_r <= 32'h00000000;
        link0_r <= 17'h00000;
        link1_r <= 17'h00000;
        busy_r <= 1'b0;
        error_r <= 1'b0;
    end else begin
        version_r <= version_number;
        link0_r <= link_status_ch0;
        link1_r <= link_status_ch1;
        busy_r <= controller_busy;
        error_r <= controller_error;
    end
end

// apb handshake: a read waits for the pipeline, a write completes at once;
// the request is taken only in the setup cycle, so a master that drops
// psel mid-read leaves the pipeline to drain on its own
always @* begin
    state_nxt = state_r;
    read_request = 1'b0;
    case (state_r)
        ST_IDLE: begin
            if (setup && !pwrite) begin
                read_request = 1'b1;
                state_nxt = ST_WAIT;
            end
        end
        ST_WAIT: begin
            if (read_valid) begin
                state_nxt = ST_DONE;
            end
        end
        ST_DONE: begin
            state_nxt = ST_IDLE;
        end
        default: begin
            state_nxt = ST_IDLE;
        end
    endcase
end

always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        state_r <= ST_IDLE;
    end else begin
        state_r <= state_nxt;
    end
end

// writes never wait; reads answer from the done state only
assign pready = pwrite ? 1'b1 : (state_r == ST_DONE);
assign pslverr = 1'b0;

// three stage delay
// a plain shift chain: no counter to clear if a request is abandoned
read_delay #(
    .DEPTH(`READ_LATENCY)
) u_read_delay (
    .clock(clock),
    .resetn(resetn),
    .read_request(read_request),
    .read_valid(read_valid)
);

// submit dword load
// entries are plain registers so the controller may read them at any time
always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        submit_dwords_ch0 <= {512{1'b0}};
        submit_dwords_ch1 <= {512{1'b0}};
    end else if (write_access && full_word) begin
        if (in_range(addr, `SUBMIT_BASE, `SUBMIT_CH1 - 18'h00004)) begin
            submit_dwords_ch0[addr[5:2]*32 +: 32] <= pwdata;
        end else if (in_range(addr, `SUBMIT_CH1, `SUBMIT_LAST)) begin
            submit_dwords_ch1[addr[5:2]*32 +: 32] <= pwdata;
        end
    end
end

// first mismatch capture, rearmed by each test start
// a mismatch in the same cycle as test start is kept: it belongs to the
// new test, and dropping it would hide a failure on the first word
always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        mismatch_seen_r <= 1'b0;
        fail_address_r <= {57{1'b0}};
        expected_r <= {512{1'b0}};
        received_r <= {512{1'b0}};
    end else if (mismatch && (test_start || !mismatch_seen_r)) begin
        mismatch_seen_r <= 1'b1;
        fail_address_r <= mismatch_address;
        expected_r <= expected_data;
        received_r <= received_data;
    end else if (test_start) begin
        mismatch_seen_r <= 1'b0;
    end
end

// first stage of read decode: a register value, or a memory to ask;
// the memories are addressed from the setup cycle in the block below
always @* begin
    direct_data = 32'h00000000;
    direct_source = SRC_DIRECT;
    if (in_range(addr, `COMPLETE_BASE, `COMPLETE_LAST)) begin
        if (addr < `COMPLETE_CH1) begin
            direct_data = complete_dwords_ch0[addr[3:2]*32 +: 32];
        end else begin
            direct_data = complete_dwords_ch1[addr[3:2]*32 +: 32];
        end
    end else if (addr == `VERSION_ADDR) begin
        direct_data = version_r;
    end else if (addr == `USER_STATUS_ADDR) begin
        direct_data = {29'h00000000, mismatch_seen_r, error_r, busy_r};
    end else if (addr == `LINK_STATUS_CH0) begin
        direct_data = {15'h0000, link0_r};
    end else if (addr == `LINK_STATUS_CH1) begin
        direct_data = {15'h0000, link1_r};
    end else if (in_range(addr, `STATUS_REGION_LO, `STATUS_REGION_HI)) begin
        if (addr == `FAIL_ADDR_LOW) begin
            direct_data = fail_address_r[31:0];
        end else if (addr == `FAIL_ADDR_HIGH) begin
            direct_data = {7'h00, fail_address_r[56:32]};
        end else if (addr == `TESTED_LOW) begin
            direct_data = tested_bytes[31:0];
        end else if (addr == `TESTED_HIGH) begin
            direct_data = {7'h00, tested_bytes[56:32]};
        end else if (in_range(addr, `EXPECTED_BASE, `EXPECTED_LAST)) begin
            direct_data = word16(expected_r, addr[5:2]);
        end else if (in_range(addr, `RECEIVED_BASE, `RECEIVED_LAST)) begin
            direct_data = word16(received_r, addr[5:2]);
        end
    end else if (in_range(addr, `CH0_CTRL_IDENT, `IDENT_LAST)) begin
        direct_source = SRC_IDENT;
    end else if (in_custom_window(addr)) begin
        direct_source = SRC_CUSTOM;
    end
end

// drive memory ports in the setup cycle, a write only into custom memory;
// addressing from setup gives the memories a full cycle before the word
// is needed, which is what lets the read keep its fixed latency
always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        ident_addr <= {MEM_ADDR_W{1'b0}};
        ident_select <= 2'd0;
        custom_memory_addr <= {MEM_ADDR_W{1'b0}};
        custom_memory_sel <= 1'b0;
        custom_memory_wr <= 1'b0;
        custom_memory_wdata <= 32'h00000000;
    end else begin
        custom_memory_wr <= 1'b0;
        if (setup) begin
            ident_addr <= {1'b0, addr[11:2]}; // 4 KB window of words
            ident_select <= addr[13:12];
            custom_memory_addr <= addr[12:2];
            custom_memory_sel <= addr[13];
            custom_memory_wdata <= pwdata;
            // writes only reach the read write window
            if (pwrite && in_custom_window(addr)) begin
                custom_memory_wr <= 1'b1;
            end
        end
    end
end

// pipeline: stage1 direct data, stage2 memory mux, stage3 to prdata;
// source_r holds for the whole read, so stage2 reloads until the memory
// word has settled and the last load before read valid is the good one
always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        read_stage1_r <= 32'h00000000;
        read_stage2_r <= 32'h00000000;
        source_r <= SRC_DIRECT;
        prdata <= 32'h00000000;
    end else begin
        if (read_request) begin
            read_stage1_r <= direct_data;
            source_r <= direct_source;
        end
        // memories answer one cycle after their address, and the address
        // stays put until the next setup cycle
        if (source_r == SRC_IDENT) begin
            read_stage2_r <= ident_rdata;
        end else if (source_r == SRC_CUSTOM) begin
            read_stage2_r <= custom_memory_rdata;
        end else begin
            read_stage2_r <= read_stage1_r;
        end
        if (read_valid) begin
            prdata <= read_stage2_r;
        end
    end
end

endmodule

// ==== rtl/user_reg_defines.vh ====
`ifndef USER_REG_DEFINES_VH
`define USER_REG_DEFINES_VH
// byte offsets of the upper register map
`define SUBMIT_BASE 18'h00400
`define SUBMIT_CH1 18'h00440
`define SUBMIT_LAST 18'h0047C
`define COMPLETE_BASE 18'h00500
`define COMPLETE_CH1 18'h00510
`define COMPLETE_LAST 18'h0051C
`define CUSTOM_REGION_LO 18'h00400
`define CUSTOM_REGION_HI 18'h00FFF
`define VERSION_ADDR 18'h00800
`define STATUS_REGION_LO 18'h01000
`define STATUS_REGION_HI 18'h01FFF
`define FAIL_ADDR_LOW 18'h01000
`define FAIL_ADDR_HIGH 18'h01004
`define TESTED_LOW 18'h01008
`define TESTED_HIGH 18'h0100C
`define EXPECTED_BASE 18'h01200
`define EXPECTED_LAST 18'h0123C
`define RECEIVED_BASE 18'h01400
`define RECEIVED_LAST 18'h0143C
`define CH0_CTRL_IDENT 18'h10000
`define CH0_NAME_IDENT 18'h11000
`define CH1_CTRL_IDENT 18'h12000
`define CH1_NAME_IDENT 18'h13000
`define IDENT_LAST 18'h13FFF
`define CUSTOM_MEM_CH0 18'h18000
`define CUSTOM_MEM_CH1 18'h1A000
`define CUSTOM_MEM_LAST 18'h1BFFF
// lower status registers
`define USER_STATUS_ADDR 18'h00100
`define LINK_STATUS_CH0 18'h00120
`define LINK_STATUS_CH1 18'h00124
// field positions
`define BUSY_BIT 0
`define ERROR_BIT 1
`define VERIFY_FAIL_BIT 2
`define HIGH_WORD_BITS 25
// read pipeline depth
`define READ_LATENCY 3
`endif

// ==== rtl/read_delay.v ====
`timescale 1ns/10ps
// delays the read request by a chain of flip-flops to form read valid
module read_delay #(
    parameter DEPTH = 3
) (
    // clock and reset
    input wire clock,
    input wire resetn,
    // request and strobe
    input wire read_request,
    output wire read_valid
);

reg [DEPTH-1:0] stage_r;

// shift the request one stage per clock
always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        stage_r <= {DEPTH{1'b0}};
    end else begin
        stage_r <= {stage_r[DEPTH-2:0], read_request};
    end
end

assign read_valid = stage_r[DEPTH-1];

endmodule

// ==== test/user_reg_props.sv ====
`timescale 1ns/10ps
// port-level checks of the upper register map
module user_reg_props (
    // clock and apb
    input wire clock,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [17:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    // sources, entries and memory port
    input wire [31:0] version_number,
    input wire [127:0] complete_dwords_ch0,
    input wire [511:0] submit_dwords_ch0,
    input wire [10:0] custom_memory_addr,
    input wire custom_memory_sel,
    input wire custom_memory_wr,
    input wire [31:0] custom_memory_wdata
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // access cycles as the slave sees them
    wire wr = psel && penable && pwrite;
    wire rd = psel && penable && !pwrite && pready;
    property p_rd_lat;
        psel && !penable && !pwrite |=> !pready [*3] ##1 pready;
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer not in fourth access cycle");
    property p_wr_rdy;
        wr |-> pready;
    endproperty
    a_wr_rdy: assert property (p_wr_rdy)
        else $error("write not answered at once");
    property p_no_err;
        psel |-> !pslverr;
    endproperty
    a_no_err: assert property (p_no_err)
        else $error("error response seen");
    property p_version;
        rd && paddr == 18'h00800 |-> prdata == version_number;
    endproperty
    a_version: assert property (p_version)
        else $error("version read wrong");
    property p_complete;
        rd && paddr[17:4] == 14'h0050
            |-> prdata == complete_dwords_ch0[paddr[3:2]*32 +: 32];
    endproperty
    a_complete: assert property (p_complete)
        else $error("completion dword wrong");
    property p_submit;
        wr && pstrb == 4'hF && paddr[17:6] == 12'h010 |=>
            submit_dwords_ch0[$past(paddr[5:2])*32 +: 32] == $past(pwdata);
    endproperty
    a_submit: assert property (p_submit)
        else $error("submit dword not loaded");
    property p_status_ro;
        wr && paddr[17:12] == 6'h01 |-> !custom_memory_wr
            ##1 $stable(submit_dwords_ch0);
    endproperty
    a_status_ro: assert property (p_status_ro)
        else $error("write to status region had an effect");
    property p_mem_wr;
        wr && paddr[17:14] == 4'h6 |-> custom_memory_wr
            && custom_memory_sel == paddr[13]
            && custom_memory_addr == paddr[12:2]
            && custom_memory_wdata == pwdata;
    endproperty
    a_mem_wr: assert property (p_mem_wr)
        else $error("custom memory write wrong");
endmodule
bind user_reg_upper user_reg_props u_props (.*);

// ==== test/mem_model.sv ====
`timescale 1ns/10ps
// identify and custom memories behind the bank, one cycle read latency
module mem_model (
    // clock
    input wire clock,
    // identify read port
    input wire [10:0] ident_addr,
    input wire [1:0] ident_select,
    output logic [31:0] ident_rdata,
    // custom memory port
    input wire [10:0] custom_memory_addr,
    input wire custom_memory_sel,
    input wire custom_memory_wr,
    input wire [31:0] custom_memory_wdata,
    output logic [31:0] custom_memory_rdata
);
    logic [31:0] cmem [0:4095];
    // identify pages hold a pattern of page and word, so reads are predictable
    // page and window contents
    always @(posedge clock) begin
        ident_rdata <= {8'hA5, 11'h0, ident_select, ident_addr};
        custom_memory_rdata <= cmem[{custom_memory_sel, custom_memory_addr}];
        if (custom_memory_wr)
            cmem[{custom_memory_sel, custom_memory_addr}] <= custom_memory_wdata;
    end
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
// self-checking bench for the upper register map
module tb_top;
    logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, busy = 0, err = 0, test_start = 0, mismatch = 0;
    logic [17:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, version_number = 0, id_rd, cm_rd, r, v;
    logic [3:0] pstrb = 0;
    logic [16:0] ls0 = 0, ls1 = 0;
    logic [255:0] cd = 0;
    wire [1023:0] sd;
    logic [1023:0] ex;
    logic [56:0] ma = 0, tb = 0;
    logic [511:0] ed = 0, rd = 0;
    logic [10:0] ia, ca;
    logic [1:0] isel;
    logic cs, cw;
    logic [31:0] cwd;
    int errors = 0, n_checks = 0, cyc = 0, j;
    user_reg_upper u_dut (.clock(clock), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .controller_busy(busy), .controller_error(err),
        .version_number(version_number), .link_status_ch0(ls0),
        .link_status_ch1(ls1), .submit_dwords_ch0(sd[511:0]),
        .submit_dwords_ch1(sd[1023:512]), .complete_dwords_ch0(cd[127:0]),
        .complete_dwords_ch1(cd[255:128]), .test_start(test_start),
        .mismatch(mismatch), .mismatch_address(ma), .tested_bytes(tb),
        .expected_data(ed), .received_data(rd), .ident_addr(ia),
        .ident_select(isel), .ident_rdata(id_rd), .custom_memory_addr(ca),
        .custom_memory_sel(cs), .custom_memory_wr(cw),
        .custom_memory_wdata(cwd), .custom_memory_rdata(cm_rd));
    mem_model u_mem (.clock(clock), .ident_addr(ia), .ident_select(isel),
        .ident_rdata(id_rd), .custom_memory_addr(ca), .custom_memory_sel(cs),
        .custom_memory_wr(cw), .custom_memory_wdata(cwd),
        .custom_memory_rdata(cm_rd));
    // 25 MHz clock
    always #20 clock = ~clock;
    // cut a hang short
    always @(posedge clock) begin
        cyc++;
        if (cyc > 20000) begin
            errors++;
            conclude;
        end
    end
    // one apb transfer; pready and prdata are taken at the rising edge,
    // before the design's own updates of that edge; read data lands in r
    task automatic xfer(input logic w, input logic [17:0] a,
        input logic [31:0] d, input logic [3:0] s);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge clock);
    endtask
    task automatic cmp(input logic [31:0] e, g, input logic [17:0] a);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %h exp %h got %h", a, e, g);
        end
    endtask
    task automatic chk(input logic [17:0] a, input logic [31:0] e);
        xfer(0, a, 0, 4'hF);
        cmp(e, r, a);
    endtask
    // firmware start-up: wait for both links, then for the core to idle
    task automatic startup;
        do xfer(0, 18'h00120, 0, 4'hF); while (r[0] !== 1'b1);
        do xfer(0, 18'h00124, 0, 4'hF); while (r[0] !== 1'b1);
        do xfer(0, 18'h00100, 0, 4'hF); while (r[1:0] === 2'b01);
        cmp(32'h0, 32'(r[1:0]), 18'h00100);
        xfer(0, 18'h00120, 0, 4'hF);
        cmp(32'(ls0[16:2]), 32'(r[16:2]), 18'h00120);
    endtask
    task automatic conclude;
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // failure capture: two mismatches in a row, the first one must stick
    task automatic fail_run;
        test_start <= 1;
        @(posedge clock);
        test_start <= 0;
        mismatch <= 1;
        repeat (2) @(posedge clock);
        mismatch <= 0;
        @(posedge clock);
    endtask
    initial begin
        r = $urandom(14);
        repeat (3) @(posedge clock);
        resetn <= 1;
        busy <= 1;
        @(posedge clock);
        // links come up after a while, then the core leaves its busy state
        fork
            begin
                repeat (20) @(posedge clock);
                ls0 <= {1'b1, 2'b00, 6'($urandom), 1'b0, 3'b100, 4'b1101};
                ls1 <= {1'b1, 2'b00, 6'($urandom), 1'b0, 3'b100, 4'b1101};
                repeat (20) @(posedge clock);
                busy <= 0;
            end
            startup;
        join
        {busy, err} <= 2'($urandom);
        version_number <= $urandom;
        ls0 <= 17'($urandom);
        ls1 <= 17'($urandom);
        tb <= {25'($urandom), 32'($urandom)};
        for (int i = 0; i < 8; i++) cd[i*32 +: 32] <= $urandom;
        repeat (2) @(posedge clock);
        chk(18'h00100, {29'h0, 1'b0, err, busy});
        chk(18'h00120, {15'h0, ls0});
        chk(18'h00124, {15'h0, ls1});
        chk(18'h00800, version_number);
        for (int i = 0; i < 8; i++) chk(18'h500 + 4 * i, cd[i*32 +: 32]);
        // submission entries, then refused writes
        for (int i = 0; i < 32; i++) begin
            ex[i*32 +: 32] = $urandom;
            xfer(1, 18'h400 + 4 * i, ex[i*32 +: 32], 4'hF);
        end
        xfer(1, 18'h00400, ~ex[31:0], 4'h3);
        xfer(1, 18'h00800, 32'h0, 4'hF);
        for (int i = 0; i < 32; i++) cmp(ex[i*32 +: 32], sd[i*32 +: 32], 0);
        chk(18'h00600, 32'h0);
        chk(18'h00800, version_number);
        ma <= {25'($urandom), 32'($urandom)};
        for (int i = 0; i < 16; i++) ed[i*32 +: 32] <= $urandom;
        for (int i = 0; i < 16; i++) rd[i*32 +: 32] <= $urandom;
        fork
            fail_run;
            begin
                repeat (2) @(posedge clock);
                ma <= ~ma;
                ed <= ~ed;
                rd <= ~rd;
            end
        join
        xfer(1, 18'h01000, 32'h0, 4'hF);
        chk(18'h01000, ~ma[31:0]);
        chk(18'h01004, {7'h0, ~ma[56:32]});
        chk(18'h01008, tb[31:0]);
        chk(18'h0100C, {7'h0, tb[56:32]});
        for (int i = 0; i < 16; i++) chk(18'h1200 + 4 * i, ~ed[i*32 +: 32]);
        for (int i = 0; i < 16; i++) chk(18'h1400 + 4 * i, ~rd[i*32 +: 32]);
        chk(18'h00100, {29'h0, 1'b1, err, busy});
        fail_run;
        chk(18'h01000, ma[31:0]);
        // identify pages and custom memory windows
        for (int s = 0; s < 4; s++) begin
            j = $urandom % 1024;
            chk(18'h10000 + s * 4096 + j * 4, {8'hA5, 11'h0, 2'(s), 11'(j)});
        end
        for (int c = 0; c < 2; c++) begin
            j = $urandom % 2048;
            v = $urandom;
            xfer(1, 18'h18000 + c * 8192 + j * 4, v, 4'hF);
            chk(18'h18000 + c * 8192 + j * 4, v);
        end
        conclude;
    end
endmodule
